// ### rtl/trim_pkg.sv
// Package for the offset and full-scale trim register bank.
// Shared by the bank and its per-register storage module.
package trim_pkg;

    // Register addresses on the control write port
    localparam logic [3:0] ADDR_OFFSET = 4'h2;
    localparam logic [3:0] ADDR_GAIN = 4'h3;

    // Values after reset
    localparam logic [15:0] RST_OFFSET = 16'h007f;
    localparam logic [15:0] RST_GAIN = 16'h807f;

    // Field positions
    localparam int OFS_MAG_MSB = 15;
    localparam int OFS_MAG_LSB = 8;
    localparam int OFS_SIGN_BIT = 7;
    localparam int GAIN_MSB = 15;
    localparam int GAIN_LSB = 7;
    localparam int FILL_MSB = 6;

    // Gain code landmarks and full-scale figures in mV peak-to-peak
    localparam logic [8:0] GAIN_NOMINAL = 9'h100;
    localparam logic [8:0] GAIN_MAX = 9'h1ff;
    localparam logic [9:0] FS_MIN_MV = 10'h230;
    localparam logic [9:0] FS_NOM_MV = 10'h2bc;
    localparam logic [9:0] FS_MAX_MV = 10'h348;
    localparam logic [9:0] FS_SPAN_MV = 10'h118;
    localparam int GAIN_CODE_BITS = 9;

    // Offset span in mV, each sign
    localparam int OFS_SPAN_MV = 45;

    // One word delivered by the serial control deframer
    typedef struct packed {
        logic en;
        logic [3:0] addr;
        logic [15:0] data;
    } trim_wr_s;

    // Trim settings as applied to the analog front end
    typedef struct packed {
        logic offset_neg;
        logic [7:0] offset_mag;
        logic [8:0] gain_code;
        logic [9:0] fs_mv;
    } trim_out_s;

endpackage : trim_pkg

// ### rtl/trim_word.sv
// One write-only 16-bit trim word with address decode.
// Assumes writes arrive as single-cycle strobes on sys_clk.
`timescale 1ns/100ps
module trim_word #(
    parameter logic [3:0] ADDR = 4'h0,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Write port
    input wire trim_pkg::trim_wr_s wr,
    // Stored word
    output logic [15:0] value
);
    import trim_pkg::*;

    logic [15:0] value_reg;
    logic [15:0] value_next;
    logic hit;

    assign hit = wr.en && (wr.addr == ADDR);

    always_comb begin
        value_next = value_reg;
        if (hit) begin
            value_next = wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

    a_word_write_lands: assert property (@(posedge sys_clk) disable iff (rst)
        hit |=> value == $past(wr.data))
        else $error("trim word did not take written data");

endmodule : trim_word

// ### rtl/trim_bank.sv
// Offset and full-scale trim register bank of the converter control block.
// Assumes a serial deframer delivers whole 16-bit words with a 4-bit address
// as one-cycle strobes, and that ext_mode is synchronous to sys_clk.
`timescale 1ns/100ps
module trim_bank #(
    parameter int GAIN_BITS = 9
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control mode: high selects extended register control
    input wire logic ext_mode,
    // Write port from the serial control deframer
    input wire trim_pkg::trim_wr_s wr,
    // Applied trim settings
    output trim_pkg::trim_out_s trim,
    // Pulses one cycle when an applied full-scale value changes
    output logic gain_changed
);
    import trim_pkg::*;

    // Only a 9-bit gain code is served by the full-scale map
    if (GAIN_BITS != GAIN_CODE_BITS) begin : g_gain_bits_check
        $error("trim_bank supports a 9-bit gain code only");
    end

    logic [15:0] offset_word;
    logic [15:0] gain_word;
    logic [8:0] gain_field;
    logic [17:0] scaled;
    logic [9:0] fs_calc;

    trim_out_s trim_reg;
    trim_out_s trim_next;
    logic gain_changed_reg;
    logic gain_changed_next;

    // Write-only storage; no read path exists
    trim_word #(
        .ADDR(ADDR_OFFSET),
        .RESET_VAL(RST_OFFSET)
    ) u_offset (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr(wr),
        .value(offset_word)
    );

    // Gain word resets to code 100h
    trim_word #(
        .ADDR(ADDR_GAIN),
        .RESET_VAL(RST_GAIN)
    ) u_gain (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr(wr),
        .value(gain_word)
    );

    assign gain_field = gain_word[GAIN_MSB:GAIN_LSB];

    // Linear map 560..840 mV over the 9-bit code, monotonic
    always_comb begin
        scaled = 18'(gain_field) * 18'(FS_SPAN_MV);
        fs_calc = FS_MIN_MV + 10'(scaled >> GAIN_CODE_BITS);
        if (gain_field == GAIN_MAX) begin
            fs_calc = FS_MAX_MV;
        end
    end

    // Pin mode holds neutral trims; extended mode passes stored fields
    always_comb begin
        trim_next = trim_reg;
        if (ext_mode) begin
            trim_next.offset_neg = offset_word[OFS_SIGN_BIT];
            trim_next.offset_mag = offset_word[OFS_MAG_MSB:OFS_MAG_LSB];
            trim_next.gain_code = gain_field;
            trim_next.fs_mv = fs_calc;
        end else begin
            trim_next.offset_neg = 1'b0;
            trim_next.offset_mag = 8'h00;
            trim_next.gain_code = GAIN_NOMINAL;
            trim_next.fs_mv = FS_NOM_MV;
        end
        gain_changed_next = (trim_next.fs_mv != trim_reg.fs_mv);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trim_reg.offset_neg <= 1'b0;
            trim_reg.offset_mag <= 8'h00;
            trim_reg.gain_code <= GAIN_NOMINAL;
            trim_reg.fs_mv <= FS_NOM_MV;
            gain_changed_reg <= 1'b0;
        end else begin
            trim_reg <= trim_next;
            gain_changed_reg <= gain_changed_next;
        end
    end

    assign trim = trim_reg;
    assign gain_changed = gain_changed_reg;

    // Offset path checks
    a_sign_follows_bit: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_OFFSET && ext_mode) ##1 ext_mode
        |=> trim.offset_neg == $past(wr.data[OFS_SIGN_BIT], 2))
        else $error("offset sign does not follow bit 7");

    a_mag_follows_field: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_OFFSET && ext_mode) ##1 ext_mode
        |=> trim.offset_mag == $past(wr.data[OFS_MAG_MSB:OFS_MAG_LSB], 2))
        else $error("offset magnitude does not follow its field");

    a_zero_mag_sign: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) && $past(ext_mode)
        && $past(offset_word[OFS_MAG_MSB:OFS_MAG_LSB]) == 8'h00
        |-> trim.offset_mag == 8'h00
        && trim.offset_neg == $past(offset_word[OFS_SIGN_BIT]))
        else $error("sign of a zero offset magnitude lost");

    // Gain path checks
    a_gain_code_field: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) && $past(ext_mode)
        |-> trim.gain_code == $past(gain_word[GAIN_MSB:GAIN_LSB]))
        else $error("gain code does not follow bits 15 to 7");

    a_gain_monotonic: assert property (@(posedge sys_clk) disable iff (rst)
        (trim.gain_code > $past(trim.gain_code) |-> trim.fs_mv >= $past(trim.fs_mv)) and
        (10'(trim.gain_code) > 10'($past(trim.gain_code)) + 10'h001
        |-> trim.fs_mv > $past(trim.fs_mv)))
        else $error("full scale not monotonic in gain code");

    a_gain_map_points: assert property (@(posedge sys_clk) disable iff (rst)
        (trim.gain_code == 9'h000 |-> trim.fs_mv == FS_MIN_MV) and
        (trim.gain_code == GAIN_NOMINAL |-> trim.fs_mv == FS_NOM_MV) and
        (trim.gain_code == GAIN_MAX |-> trim.fs_mv == FS_MAX_MV))
        else $error("full scale landmark wrong");

    a_fs_range_bounds: assert property (@(posedge sys_clk) disable iff (rst)
        trim.fs_mv >= FS_MIN_MV && trim.fs_mv <= FS_MAX_MV)
        else $error("full scale outside its span");

    a_gain_applies_direct: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_GAIN && ext_mode) ##1 ext_mode
        |=> trim.gain_code == $past(wr.data[GAIN_MSB:GAIN_LSB], 2))
        else $error("new gain code not applied two cycles after write");

    a_change_pulse_marks: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(rst) |-> gain_changed == (trim.fs_mv != $past(trim.fs_mv)))
        else $error("change pulse does not match a full-scale change");

    // Reset checks
    a_gain_reset_value: assert property (@(posedge sys_clk)
        $past(rst) |-> trim.gain_code == GAIN_NOMINAL && trim.fs_mv == FS_NOM_MV)
        else $error("gain not nominal after reset");

    a_offset_reset_value: assert property (@(posedge sys_clk)
        $past(rst) |-> !trim.offset_neg && trim.offset_mag == 8'h00 && !gain_changed)
        else $error("offset or change pulse not cleared after reset");

    a_stored_words_reset: assert property (@(posedge sys_clk)
        $past(rst) |-> offset_word == RST_OFFSET && gain_word == RST_GAIN)
        else $error("stored trim words not at their reset values");

    // Mode and storage checks
    a_pin_mode_neutral: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_mode ##1 !ext_mode |-> !trim.offset_neg && trim.offset_mag == 8'h00
        && trim.gain_code == GAIN_NOMINAL && trim.fs_mv == FS_NOM_MV)
        else $error("trims leak in pin mode");

    a_pin_mode_still: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_mode ##1 !ext_mode |=> $stable(trim))
        else $error("trims moved while in pin mode");

    a_mode_entry_applies: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_mode ##1 ext_mode |=> trim.gain_code == $past(gain_word[GAIN_MSB:GAIN_LSB])
        && trim.offset_neg == $past(offset_word[OFS_SIGN_BIT]))
        else $error("stored trims not applied on entering extended mode");

    a_write_only_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!wr.en && ext_mode) ##1 ext_mode |=> $stable(trim))
        else $error("trims changed without a write");

    a_refused_addr_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr != ADDR_OFFSET && wr.addr != ADDR_GAIN && ext_mode)
        ##1 (!wr.en && ext_mode) |=> $stable(trim))
        else $error("write to another address changed the trims");

    a_offset_keeps_gain: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_OFFSET && ext_mode) ##1 (!wr.en && ext_mode)
        |=> $stable(trim.gain_code) && $stable(trim.fs_mv))
        else $error("offset write disturbed the gain trim");

    a_gain_keeps_offset: assert property (@(posedge sys_clk) disable iff (rst)
        (wr.en && wr.addr == ADDR_GAIN && ext_mode) ##1 (!wr.en && ext_mode)
        |=> $stable(trim.offset_neg) && $stable(trim.offset_mag))
        else $error("gain write disturbed the offset trim");

    // Coverage of the main scenarios
    c_gain_write: cover property (@(posedge sys_clk) disable iff (rst)
        ext_mode && wr.en && wr.addr == ADDR_GAIN ##2 gain_changed);

    c_neg_zero: cover property (@(posedge sys_clk) disable iff (rst)
        trim.offset_neg && trim.offset_mag == 8'h00);

    c_mode_drop: cover property (@(posedge sys_clk) disable iff (rst)
        ext_mode ##1 !ext_mode);

    c_gain_max: cover property (@(posedge sys_clk) disable iff (rst)
        trim.fs_mv == FS_MAX_MV);

    c_mode_return: cover property (@(posedge sys_clk) disable iff (rst)
        !ext_mode ##1 ext_mode ##1 gain_changed);

endmodule : trim_bank

// ### tb/host_ctrl.sv
// Host controller model that writes whole trim words on the bank's write port.
// Assumes the bank takes a word on the rising sys_clk edge that sees en high.
`timescale 1ns/100ps
module host_ctrl (
    // Clock
    input wire logic sys_clk,
    // Write port
    output trim_pkg::trim_wr_s wr
);
    import trim_pkg::*;
    initial wr = '0;
    // Field f fills bits 15:7, low bits always ones
    task automatic send(input logic [3:0] a, input logic [8:0] f);
        @(posedge sys_clk);
        wr <= '{en: 1'b1, addr: a, data: {f, 7'h7f}};
        @(posedge sys_clk);
        wr <= '{en: 1'b0, addr: ~a, data: ~{f, 7'h7f}};
    endtask : send
endmodule : host_ctrl

// ### tb/tb_top.sv
// Self-checking bench for the trim register bank.
// Assumes the host model in host_ctrl.sv drives the write port.
`timescale 1ns/100ps
module tb_top;
    import trim_pkg::*;
    localparam logic [27:0] NEUTRAL = {1'b0, 8'h00, 9'h100, 10'h2bc};
    logic sys_clk, rst, ext_mode, gain_changed;
    logic [9:0] prev;
    trim_wr_s wr;
    trim_out_s trim;
    int n_fail = 0;
    int samples_checked = 0;
    trim_bank dut_u (.sys_clk(sys_clk), .rst(rst), .ext_mode(ext_mode), .wr(wr),
        .trim(trim), .gain_changed(gain_changed));
    host_ctrl host_u (.sys_clk(sys_clk), .wr(wr));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Write, then wait until the word reaches the applied outputs
    task automatic put(input logic [3:0] a, input logic [8:0] f);
        host_u.send(a, f);
        @(posedge sys_clk);
        #1;
    endtask : put
    task automatic do_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(trim, NEUTRAL);
        chk(28'(gain_changed), 28'h0);
        $display("test reset done");
    endtask : do_reset
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        ext_mode = 1'b1;
        do_reset();
        put(ADDR_GAIN, 9'h000);
        chk(28'(trim.fs_mv), 28'h230);
        chk(28'(gain_changed), 28'h1);
        @(posedge sys_clk);
        #1;
        chk(28'(gain_changed), 28'h0);
        put(ADDR_GAIN, 9'h1ff);
        chk(28'(trim.fs_mv), 28'h348);
        put(ADDR_GAIN, 9'h100);
        chk(28'(trim.fs_mv), 28'h2bc);
        prev = 10'h000;
        for (int c = 10'h0c0; c <= 10'h1c0; c += 10'h040) begin
            put(ADDR_GAIN, 9'(c));
            chk(28'(trim.gain_code), 28'(c));
            chk(28'(trim.fs_mv > prev), 28'h1);
            prev = trim.fs_mv;
        end
        $display("test gain done");
        put(ADDR_OFFSET, {8'h00, 1'b1});
        chk(28'({trim.offset_neg, trim.offset_mag}), 28'h100);
        put(ADDR_OFFSET, {8'ha5, 1'b0});
        chk(28'({trim.offset_neg, trim.offset_mag}), 28'h0a5);
        put(4'h4, 9'h000);
        chk(28'(trim.gain_code), 28'h1c0);
        $display("test offset done");
        @(posedge sys_clk);
        ext_mode <= 1'b0;
        put(ADDR_GAIN, 9'h0e0);
        chk(trim, NEUTRAL);
        @(posedge sys_clk);
        ext_mode <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(trim, {1'b0, 8'ha5, 9'h0e0, 10'h2aa});
        $display("test mode done");
        do_reset();
        give_verdict();
    end
endmodule : tb_top
